// ==== liu_status_pkg.sv ====
// Shared constants, field positions and carrier types of the line status block
package liu_status_pkg;

    // Register indices; byte address is four times the index
    localparam logic [12:0] IDX_LIVE = 13'h1003;
    localparam logic [12:0] IDX_ENABLE = 13'h1004;
    localparam logic [12:0] IDX_LATCH = 13'h1005;
    localparam logic [12:0] IDX_LEVEL = 13'h1006;
    localparam logic [12:0] IDX_TERM = 13'h1007;
    localparam logic [12:0] IDX_RXCTL = 13'h1008;
    localparam logic [12:0] IDX_MODE = 13'h1009;

    // Field positions
    localparam int unsigned LIVE_JITTER_BIT = 7;
    localparam int unsigned LEVEL_LSB = 4;
    localparam int unsigned TERM_ON_BIT = 6;
    localparam int unsigned TERM_SEL_MSB = 2;
    localparam int unsigned RXCTL_CLKIN_BIT = 7;
    localparam int unsigned RXCTL_RATIO_BIT = 3;
    localparam int unsigned RXCTL_MON_BIT = 2;
    localparam int unsigned MODE_E1_BIT = 3;

    // Writable bits; the rest read as zero
    localparam logic [7:0] WMASK_TERM = 8'h47;
    localparam logic [7:0] WMASK_RXCTL = 8'h8f;
    localparam logic [7:0] WMASK_MODE = 8'h0f;

    // Reset values
    localparam logic [7:0] RST_ENABLE = 8'h00;
    localparam logic [7:0] RST_LATCH = 8'h00;
    localparam logic [7:0] RST_TERM = 8'h00;
    localparam logic [7:0] RST_RXCTL = 8'h00;
    localparam logic [7:0] RST_MODE = 8'h00;
    localparam logic [3:0] RST_LEVEL = 4'h0;

    // First build-out code of the CSU group
    localparam logic [2:0] LBO_CSU_FIRST = 3'h5;

    // Cable loss in tenths of a dB, monitor gain in dB
    localparam logic [8:0] LOSS_N0 = 9'h078; // 12.0
    localparam logic [8:0] LOSS_N1 = 9'h0c8; // 20.0
    localparam logic [8:0] LOSS_N2 = 9'h12c; // 30.0
    localparam logic [8:0] LOSS_N3_T1 = 9'h168; // 36.0
    localparam logic [8:0] LOSS_N3_E1 = 9'h1ae; // 43.0
    localparam logic [8:0] LOSS_M0 = 9'h12c; // 30.0
    localparam logic [8:0] LOSS_M1 = 9'h0e1; // 22.5
    localparam logic [8:0] LOSS_M2 = 9'h0af; // 17.5
    localparam logic [8:0] LOSS_M3 = 9'h078; // 12.0
    localparam logic [5:0] GAIN_M0 = 6'h0e; // 14
    localparam logic [5:0] GAIN_M1 = 6'h14; // 20
    localparam logic [5:0] GAIN_M2 = 6'h1a; // 26
    localparam logic [5:0] GAIN_M3 = 6'h20; // 32

    // Bus answers
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // AXI4-Lite signals from the master
    typedef struct packed {
        logic awvalid;
        logic [15:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [15:0] araddr;
        logic rready;
    } axi_req_t;

    // AXI4-Lite signals back to the master
    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } axi_rsp_t;

    // Live line conditions, same order as latch bits 3..0
    typedef struct packed {
        logic jitter;
        logic open;
        logic short;
        logic loss;
    } line_cond_t;

    // Decoded receive setup driven to the analog front end
    typedef struct packed {
        logic term_enable;
        logic term_ext_120;
        logic term_internal;
        logic [1:0] impedance_sel;
        logic ratio_2to1;
        logic clock_input_mode;
        logic clock_expect_e1;
        logic monitor_on;
        logic [5:0] monitor_gain_db;
        logic [8:0] max_loss_tenth_db;
    } rx_setup_t;

endpackage

// ==== liu_status_and_receive_config.sv ====
// Line status latch, interrupt gating and receive configuration behind AXI4-Lite
//
// Local design decision: the AXI4-Lite register port.
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - Mask bit zero blocks, one enables interrupt
// - Latched event bits hold; each can interrupt
// - Bit 7 set when jitter trip ends
// - Bits 6,5 set when open/short ends
// - Bit 4 set when signal loss ends
// - Bit 3 set when jitter trip starts
// - Bits 2,1 set when open/short starts
// - Open/short start events dropped in CSU build-outs
// - Bit 0 set when signal loss starts
// - Level bits 7:4 give live 2.5dB band
// - Reported band limited by equalizer gain cap
// - Bit 6 switches internal termination on
// - Three-bit select picks impedance and resistor
// - Bit 7 makes receiver expect line clock
// - Bit 3 picks 2:1 ratio, no internal match
// - Bit 2 enables monitor mode gain
// - Normal sensitivity codes give 12/20/30/36-43 dB
// - Monitor codes give 14-32 dB gain
// - Live loss status follows detector, feeds events
module liu_status_and_receive_config (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire liu_status_pkg::axi_req_t axi_i,
    output liu_status_pkg::axi_rsp_t axi_o,
    input wire liu_status_pkg::line_cond_t cond_i,
    input wire logic [3:0] level_band_i,
    input wire logic [3:0] gain_cap_band_i,
    output logic irq_o,
    output liu_status_pkg::rx_setup_t setup_o
);

    ////////////////////////////////////////////////////////////////////////////
    // State

    // Whole module state, registered as one word
    typedef struct packed {
        liu_status_pkg::axi_rsp_t rsp;
        logic aw_held; // Write address waiting for data
        logic [15:0] awaddr;
        logic w_held; // Write data waiting for address
        logic [7:0] wdata;
        logic wstrb0;
        logic [7:0] enable;
        logic [7:0] latch;
        logic [3:0] level;
        logic [7:0] term;
        logic [7:0] rxctl;
        logic [7:0] mode;
        liu_status_pkg::line_cond_t prev; // Last cycle's conditions
        logic irq;
        liu_status_pkg::rx_setup_t setup;
    } state_t;

    // Reset image: ready to take a request, all flags clear
    localparam state_t STATE_RST = '{
        rsp: '{awready: 1'b1, wready: 1'b1, bvalid: 1'b0, bresp: liu_status_pkg::RESP_OKAY,
               arready: 1'b1, rvalid: 1'b0, rdata: 32'h0000_0000,
               rresp: liu_status_pkg::RESP_OKAY},
        aw_held: 1'b0,
        awaddr: 16'h0000,
        w_held: 1'b0,
        wdata: 8'h00,
        wstrb0: 1'b0,
        enable: liu_status_pkg::RST_ENABLE,
        latch: liu_status_pkg::RST_LATCH,
        level: liu_status_pkg::RST_LEVEL,
        term: liu_status_pkg::RST_TERM,
        rxctl: liu_status_pkg::RST_RXCTL,
        mode: liu_status_pkg::RST_MODE,
        prev: 4'h0,
        irq: 1'b0,
        setup: '0
    };

    state_t s; // Current state
    state_t next_s; // Next state

    ////////////////////////////////////////////////////////////////////////////
    // Address decode

    // Word index of a byte address
    function automatic logic [12:0] reg_index(input logic [15:0] addr);
        reg_index = addr[14:2];
    endfunction

    // Aligned and inside the register group
    function automatic logic is_mapped(input logic [15:0] addr);
        is_mapped = (addr[1:0] == 2'h0) && !addr[15]
            && (reg_index(addr) >= liu_status_pkg::IDX_LIVE)
            && (reg_index(addr) <= liu_status_pkg::IDX_MODE);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Event detection

    logic csu_mode; // T1 CSU build-out selected
    logic wr_fire; // Write executes this cycle
    logic [7:0] set_ev; // Events arriving this cycle
    logic [7:0] clr_bits; // Bits software clears this cycle

    // The open and short detectors misbehave in CSU build-outs, so their start events are dropped
    assign csu_mode = !s.mode[liu_status_pkg::MODE_E1_BIT]
        && (s.mode[2:0] >= liu_status_pkg::LBO_CSU_FIRST);

    // Start of a condition: jitter and loss always, open and short outside CSU
    assign set_ev[3] = cond_i.jitter && !s.prev.jitter;
    assign set_ev[2] = cond_i.open && !s.prev.open && !csu_mode;
    assign set_ev[1] = cond_i.short && !s.prev.short && !csu_mode;
    assign set_ev[0] = cond_i.loss && !s.prev.loss;

    // End of a condition: seen before, gone now
    assign set_ev[7:4] = s.prev & ~cond_i;

    assign wr_fire = s.aw_held && s.w_held && !s.rsp.bvalid;

    // Write-one-to-clear on the latch, low byte lane only
    assign clr_bits = (wr_fire && s.wstrb0 && is_mapped(s.awaddr)
        && (reg_index(s.awaddr) == liu_status_pkg::IDX_LATCH)) ? s.wdata : 8'h00;

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    // Bus slave, register file and setup decode
    always_comb
    begin
        next_s = s;
        // Set beats clear so an event in the clearing cycle survives
        next_s.latch = (s.latch & ~clr_bits) | set_ev;
        next_s.prev = cond_i;
        // Live band, capped by the equalizer gain limit
        next_s.level = (level_band_i > gain_cap_band_i) ? gain_cap_band_i
            : level_band_i;

        // Address and data taken independently, in either order
        if (s.rsp.awready && axi_i.awvalid)
        begin
            next_s.aw_held = 1'b1;
            next_s.awaddr = axi_i.awaddr;
        end
        if (s.rsp.wready && axi_i.wvalid)
        begin
            next_s.w_held = 1'b1;
            next_s.wdata = axi_i.wdata[7:0];
            next_s.wstrb0 = axi_i.wstrb[0];
        end

        // Both halves present: commit and answer
        if (wr_fire)
        begin
            next_s.aw_held = 1'b0;
            next_s.w_held = 1'b0;
            next_s.rsp.bvalid = 1'b1;
            next_s.rsp.bresp = is_mapped(s.awaddr) ? liu_status_pkg::RESP_OKAY
                : liu_status_pkg::RESP_SLVERR;
            if (s.wstrb0 && is_mapped(s.awaddr))
            begin
                case (reg_index(s.awaddr))
                    liu_status_pkg::IDX_ENABLE: next_s.enable = s.wdata;
                    liu_status_pkg::IDX_TERM: next_s.term = s.wdata & liu_status_pkg::WMASK_TERM;
                    liu_status_pkg::IDX_RXCTL:
                        next_s.rxctl = s.wdata & liu_status_pkg::WMASK_RXCTL;
                    liu_status_pkg::IDX_MODE: next_s.mode = s.wdata & liu_status_pkg::WMASK_MODE;
                    // Latch handled above; read-only ones ignore writes
                    default: next_s.mode = s.mode;
                endcase
            end
        end
        else if (s.rsp.bvalid && axi_i.bready)
        begin
            next_s.rsp.bvalid = 1'b0;
        end
        // No new write half until the answer is gone
        next_s.rsp.awready = !next_s.aw_held && !next_s.rsp.bvalid;
        next_s.rsp.wready = !next_s.w_held && !next_s.rsp.bvalid;

        // Read: one outstanding, data captured at the address handshake
        if (s.rsp.arready && axi_i.arvalid)
        begin
            next_s.rsp.rvalid = 1'b1;
            next_s.rsp.rdata = 32'h0000_0000;
            next_s.rsp.rresp = is_mapped(axi_i.araddr) ? liu_status_pkg::RESP_OKAY
                : liu_status_pkg::RESP_SLVERR;
            if (is_mapped(axi_i.araddr))
            begin
                case (reg_index(axi_i.araddr))
                    liu_status_pkg::IDX_LIVE:
                    begin
                        next_s.rsp.rdata[3:0] = {1'b0, cond_i.short, cond_i.open, cond_i.loss};
                        next_s.rsp.rdata[liu_status_pkg::LIVE_JITTER_BIT] = cond_i.jitter;
                    end
                    liu_status_pkg::IDX_ENABLE: next_s.rsp.rdata[7:0] = s.enable;
                    liu_status_pkg::IDX_LATCH: next_s.rsp.rdata[7:0] = s.latch;
                    liu_status_pkg::IDX_LEVEL:
                        next_s.rsp.rdata[liu_status_pkg::LEVEL_LSB +: 4] = s.level;
                    liu_status_pkg::IDX_TERM: next_s.rsp.rdata[7:0] = s.term;
                    liu_status_pkg::IDX_RXCTL: next_s.rsp.rdata[7:0] = s.rxctl;
                    default: next_s.rsp.rdata[7:0] = s.mode;
                endcase
            end
        end
        else if (s.rsp.rvalid && axi_i.rready)
        begin
            next_s.rsp.rvalid = 1'b0;
        end
        next_s.rsp.arready = !next_s.rsp.rvalid;

        // Termination: 2:1 ratio has no internal match, so it forces it off
        next_s.setup.ratio_2to1 = next_s.rxctl[liu_status_pkg::RXCTL_RATIO_BIT];
        next_s.setup.term_enable = next_s.term[liu_status_pkg::TERM_ON_BIT]
            && !next_s.setup.ratio_2to1;
        next_s.setup.term_internal = next_s.setup.term_enable
            && next_s.term[liu_status_pkg::TERM_SEL_MSB];
        next_s.setup.term_ext_120 = next_s.setup.term_enable
            && !next_s.term[liu_status_pkg::TERM_SEL_MSB];
        next_s.setup.impedance_sel = next_s.term[1:0];

        // Clock input mode expects the rate of the selected line standard
        next_s.setup.clock_input_mode = next_s.rxctl[liu_status_pkg::RXCTL_CLKIN_BIT];
        next_s.setup.clock_expect_e1 = next_s.mode[liu_status_pkg::MODE_E1_BIT];

        // Sensitivity and monitor gain
        next_s.setup.monitor_on = next_s.rxctl[liu_status_pkg::RXCTL_MON_BIT];
        if (next_s.setup.monitor_on)
        begin
            case (next_s.rxctl[1:0])
                2'h0:
                begin
                    next_s.setup.monitor_gain_db = liu_status_pkg::GAIN_M0;
                    next_s.setup.max_loss_tenth_db = liu_status_pkg::LOSS_M0;
                end
                2'h1:
                begin
                    next_s.setup.monitor_gain_db = liu_status_pkg::GAIN_M1;
                    next_s.setup.max_loss_tenth_db = liu_status_pkg::LOSS_M1;
                end
                2'h2:
                begin
                    next_s.setup.monitor_gain_db = liu_status_pkg::GAIN_M2;
                    next_s.setup.max_loss_tenth_db = liu_status_pkg::LOSS_M2;
                end
                default:
                begin
                    next_s.setup.monitor_gain_db = liu_status_pkg::GAIN_M3;
                    next_s.setup.max_loss_tenth_db = liu_status_pkg::LOSS_M3;
                end
            endcase
        end
        else
        begin
            next_s.setup.monitor_gain_db = 6'h00;
            case (next_s.rxctl[1:0])
                2'h0: next_s.setup.max_loss_tenth_db = liu_status_pkg::LOSS_N0;
                2'h1: next_s.setup.max_loss_tenth_db = liu_status_pkg::LOSS_N1;
                2'h2: next_s.setup.max_loss_tenth_db = liu_status_pkg::LOSS_N2;
                default: next_s.setup.max_loss_tenth_db = next_s.setup.clock_expect_e1
                    ? liu_status_pkg::LOSS_N3_E1 : liu_status_pkg::LOSS_N3_T1;
            endcase
        end

        // Interrupt: any set event whose mask bit is one
        next_s.irq = |(next_s.latch & next_s.enable);
    end

    // State register, synchronous reset
    always_ff @(posedge clk_i)
    begin
        if (!nrst_i)
        begin
            s <= STATE_RST;
        end
        else
        begin
            s <= next_s;
        end
    end

    assign axi_o = s.rsp;
    assign irq_o = s.irq;
    assign setup_o = s.setup;

    ////////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!nrst_i);

    logic [7:0] keep_bits; // Bits that must survive the edge
    assign keep_bits = s.latch & ~clr_bits;

    a_irq_mask_gate: assert property (irq_o == |(s.latch & s.enable))
        else $error("interrupt does not follow masked events");
    // Every bit that was not cleared must still be set one edge later
    a_latch_holds: assert property (1'b1 |=> &(s.latch | ~$past(keep_bits)))
        else $error("latched event lost");
    a_jitter_end_flag: assert property ($fell(cond_i.jitter) |=> s.latch[7])
        else $error("jitter end not latched");
    a_open_end_flag: assert property ($fell(cond_i.open) |=> s.latch[6])
        else $error("open end not latched");
    a_short_end_flag: assert property ($fell(cond_i.short) |=> s.latch[5])
        else $error("short end not latched");
    a_loss_end_flag: assert property ($fell(cond_i.loss) |=> s.latch[4])
        else $error("loss end not latched");
    a_jitter_start_flag: assert property ($rose(cond_i.jitter) |=> s.latch[3])
        else $error("jitter start not latched");
    a_short_start_flag: assert property ($rose(cond_i.short) && !csu_mode |=> s.latch[1])
        else $error("short start not latched");
    a_open_start_flag: assert property ($rose(cond_i.open) && !csu_mode |=> s.latch[2])
        else $error("open start not latched");
    a_csu_blocks_open: assert property (
        $rose(cond_i.open) && csu_mode && !s.latch[2] |=> !s.latch[2])
        else $error("open flagged in CSU build-out");
    a_loss_start_flag: assert property ($rose(cond_i.loss) |=> s.latch[0])
        else $error("loss start not latched");
    a_level_capped: assert property (
        1'b1 |=> s.level == (($past(level_band_i) > $past(gain_cap_band_i))
        ? $past(gain_cap_band_i) : $past(level_band_i)))
        else $error("level band wrong");
    a_term_select: assert property (
        setup_o.term_internal == (setup_o.term_enable && s.term[2]))
        else $error("termination select decode wrong");
    a_term_ratio_off: assert property (setup_o.ratio_2to1 |-> !setup_o.term_enable)
        else $error("internal match with 2:1 ratio");
    a_clock_input: assert property (setup_o.clock_input_mode == s.rxctl[7])
        else $error("clock input mode does not follow control bit");
    a_monitor_gain: assert property (
        setup_o.monitor_on && s.rxctl[1:0] == 2'h3
        |-> setup_o.monitor_gain_db == liu_status_pkg::GAIN_M3
        && setup_o.max_loss_tenth_db == liu_status_pkg::LOSS_M3)
        else $error("monitor code 3 table wrong");
    a_clear_one: assert property (clr_bits[0] && !set_ev[0] |=> !s.latch[0])
        else $error("write one did not clear");

    c_irq_rise: cover property ($rose(irq_o));
    c_write_done: cover property (axi_o.bvalid && axi_i.bready);
    c_read_done: cover property (axi_o.rvalid && axi_i.rready);
    c_clear_race: cover property (clr_bits[0] && set_ev[0]);
    c_csu_drop: cover property ($rose(cond_i.open) && csu_mode);

endmodule

// ==== liu_status_and_receive_config_tb_top.sv ====
// Self-checking bench for the line status and receive configuration block
`timescale 1ns/100ps

module liu_status_and_receive_config_tb_top;

////////////////////////////////////////////////////////////////////////////////
// Signals, counters and the device under test
logic clk_i; // 200 MHz clock
logic nrst_i; // Synchronous reset, active low
liu_status_pkg::axi_req_t axi_i;
liu_status_pkg::axi_rsp_t axi_o;
liu_status_pkg::line_cond_t cond_i; // Live line conditions
logic [3:0] level_band_i;
logic [3:0] gain_cap_band_i;
logic irq_o;
liu_status_pkg::rx_setup_t setup_o;
int mismatches;
int comparisons;
int cycles;
localparam int CYCLE_LIMIT = 20000; // Whole run needs under a thousand cycles

liu_status_and_receive_config dut_u (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .axi_i(axi_i),
    .axi_o(axi_o),
    .cond_i(cond_i),
    .level_band_i(level_band_i),
    .gain_cap_band_i(gain_cap_band_i),
    .irq_o(irq_o),
    .setup_o(setup_o)
);

////////////////////////////////////////////////////////////////////////////////
// Clock and hang guard
initial clk_i = 1'b0;
always #2.5 clk_i = ~clk_i;

// A stuck handshake ends here rather than spinning forever
always @(posedge clk_i)
begin
    cycles++;
    if (cycles >= CYCLE_LIMIT)
    begin
        mismatches++;
        close_out();
    end
end

////////////////////////////////////////////////////////////////////////////////
// Reporting and bus tasks
task automatic close_out();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
        $display("All checks passed");
    else
        $display("Checks failed");
    $finish;
endtask

task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
        mismatches++;
        $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
endtask

// Byte address of a register index
function automatic logic [15:0] ra(input logic [12:0] idx);
    return {1'b0, idx, 2'b00};
endfunction

// Outputs are read just after the edge, so they hold what the edge sampled
task automatic wr(input logic [15:0] a, input logic [7:0] d, output logic [1:0] resp);
    @(posedge clk_i);
    axi_i.awvalid <= 1'b1;
    axi_i.awaddr <= a;
    axi_i.wvalid <= 1'b1;
    axi_i.wdata <= {24'h000000, d};
    axi_i.wstrb <= 4'hf;
    axi_i.bready <= 1'b1;
    do
    begin
        @(posedge clk_i);
        if (axi_i.awvalid && axi_o.awready)
            axi_i.awvalid <= 1'b0;
        if (axi_i.wvalid && axi_o.wready)
            axi_i.wvalid <= 1'b0;
    end while (axi_o.bvalid !== 1'b1);
    resp = axi_o.bresp;
    axi_i.bready <= 1'b0;
endtask

task automatic rd(input logic [15:0] a, output logic [31:0] d, output logic [1:0] resp);
    @(posedge clk_i);
    axi_i.arvalid <= 1'b1;
    axi_i.araddr <= a;
    axi_i.rready <= 1'b1;
    do
    begin
        @(posedge clk_i);
        if (axi_i.arvalid && axi_o.arready)
            axi_i.arvalid <= 1'b0;
    end while (axi_o.rvalid !== 1'b1);
    d = axi_o.rdata;
    resp = axi_o.rresp;
    axi_i.rready <= 1'b0;
endtask

// Register write expecting OKAY
task automatic wr_ok(input logic [12:0] idx, input logic [7:0] d);
    logic [1:0] r;
    wr(ra(idx), d, r);
    check("write resp", 32'(r), 32'(liu_status_pkg::RESP_OKAY));
endtask

// Register read compared with an expected byte
task automatic rd_check(input string what, input logic [12:0] idx, input logic [7:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    rd(ra(idx), d, r);
    check(what, d, {24'h000000, exp});
    check("read resp", 32'(r), 32'(liu_status_pkg::RESP_OKAY));
endtask

// Let register, latch and flop outputs land
task automatic settle();
    repeat (3) @(posedge clk_i);
endtask

////////////////////////////////////////////////////////////////////////////////
// Scenarios
task automatic reset_values();
    logic [31:0] d;
    logic [1:0] r;
    rd_check("enable reset", liu_status_pkg::IDX_ENABLE, 8'h00);
    rd_check("latch reset", liu_status_pkg::IDX_LATCH, 8'h00);
    rd_check("term reset", liu_status_pkg::IDX_TERM, 8'h00);
    rd_check("rxctl reset", liu_status_pkg::IDX_RXCTL, 8'h00);
    check("loss reset", 32'(setup_o.max_loss_tenth_db), 32'(liu_status_pkg::LOSS_N0));
    // Unaligned write and unmapped read are refused
    wr(16'h4015, 8'hff, r);
    check("unaligned resp", 32'(r), 32'(liu_status_pkg::RESP_SLVERR));
    rd(16'h4028, d, r);
    check("unmapped data", d, 32'h00000000);
    check("unmapped resp", 32'(r), 32'(liu_status_pkg::RESP_SLVERR));
endtask

// Each condition: start, W1C with zero, end, then both mask halves
task automatic events();
    logic [7:0] live;
    for (int k = 0; k < 4; k++)
    begin
        live = (k == 0) ? 8'h01 : (k == 1) ? 8'h04 : (k == 2) ? 8'h02 : 8'h80;
        @(posedge clk_i);
        cond_i <= liu_status_pkg::line_cond_t'(4'h1 << k);
        settle();
        rd_check("live status", liu_status_pkg::IDX_LIVE, live);
        rd_check("start event", liu_status_pkg::IDX_LATCH, 8'h01 << k);
        wr_ok(liu_status_pkg::IDX_LATCH, 8'h00);
        rd_check("zero keeps", liu_status_pkg::IDX_LATCH, 8'h01 << k);
        cond_i <= '0;
        settle();
        rd_check("end event", liu_status_pkg::IDX_LATCH, 8'h11 << k);
        check("irq masked", 32'(irq_o), 32'h0);
        wr_ok(liu_status_pkg::IDX_ENABLE, 8'h10 << k);
        settle();
        check("irq end", 32'(irq_o), 32'h1);
        wr_ok(liu_status_pkg::IDX_LATCH, 8'h10 << k);
        settle();
        check("irq after clear", 32'(irq_o), 32'h0);
        wr_ok(liu_status_pkg::IDX_ENABLE, 8'h01 << k);
        settle();
        check("irq start", 32'(irq_o), 32'h1);
        wr_ok(liu_status_pkg::IDX_LATCH, 8'hff);
        wr_ok(liu_status_pkg::IDX_ENABLE, 8'h00);
        settle();
        check("irq idle", 32'(irq_o), 32'h0);
        rd_check("latch empty", liu_status_pkg::IDX_LATCH, 8'h00);
    end
endtask

// Open start is dropped in the CSU build-outs, its end is not
task automatic csu_gate();
    for (int transmit_build_out_code = 4; transmit_build_out_code < 8; transmit_build_out_code++)
    begin
        wr_ok(liu_status_pkg::IDX_MODE, 8'(transmit_build_out_code));
        @(posedge clk_i);
        cond_i <= liu_status_pkg::line_cond_t'(4'h4);
        settle();
        cond_i <= '0;
        settle();
        rd_check("csu gate", liu_status_pkg::IDX_LATCH, (transmit_build_out_code < 5) ? 8'h44 : 8'h40);
        wr_ok(liu_status_pkg::IDX_LATCH, 8'hff);
    end
    wr_ok(liu_status_pkg::IDX_MODE, 8'h00);
endtask

task automatic level_band();
    @(posedge clk_i);
    level_band_i <= 4'h9;
    gain_cap_band_i <= 4'hf;
    settle();
    rd_check("level band", liu_status_pkg::IDX_LEVEL, 8'h90);
    gain_cap_band_i <= 4'h6;
    settle();
    rd_check("level capped", liu_status_pkg::IDX_LEVEL, 8'h60);
    level_band_i <= 4'hf;
    gain_cap_band_i <= 4'hf;
    settle();
    rd_check("level lowest", liu_status_pkg::IDX_LEVEL, 8'hf0);
endtask

// Every on/select combination, then the 2:1 override
task automatic termination();
    logic [3:0] v;
    for (int i = 0; i < 16; i++)
    begin
        v = 4'(i);
        wr_ok(liu_status_pkg::IDX_TERM, {1'b0, v[3], 3'h0, v[2:0]});
        settle();
        rd_check("term readback", liu_status_pkg::IDX_TERM, {1'b0, v[3], 3'h0, v[2:0]});
        check("term on", 32'(setup_o.term_enable), 32'(v[3]));
        check("term ext", 32'(setup_o.term_ext_120), 32'(v[3] & ~v[2]));
        check("term int", 32'(setup_o.term_internal), 32'(v[3] & v[2]));
        check("impedance", 32'(setup_o.impedance_sel), 32'(v[1:0]));
    end
    wr_ok(liu_status_pkg::IDX_RXCTL, 8'h08);
    wr_ok(liu_status_pkg::IDX_TERM, 8'h44);
    settle();
    check("ratio", 32'(setup_o.ratio_2to1), 32'h1);
    check("no match 2to1", 32'(setup_o.term_enable), 32'h0);
endtask

// Sensitivity and monitor tables, with T1 and E1 for each code
task automatic rx_control();
    logic [3:0] v;
    logic [5:0] g;
    logic [8:0] l;
    for (int i = 0; i < 16; i++)
    begin
        v = 4'(i);
        g = 6'h00;
        case ({v[2], v[1:0]})
            3'h0: l = liu_status_pkg::LOSS_N0;
            3'h1: l = liu_status_pkg::LOSS_N1;
            3'h2: l = liu_status_pkg::LOSS_N2;
            3'h3: l = v[3] ? liu_status_pkg::LOSS_N3_E1 : liu_status_pkg::LOSS_N3_T1;
            3'h4: {g, l} = {liu_status_pkg::GAIN_M0, liu_status_pkg::LOSS_M0};
            3'h5: {g, l} = {liu_status_pkg::GAIN_M1, liu_status_pkg::LOSS_M1};
            3'h6: {g, l} = {liu_status_pkg::GAIN_M2, liu_status_pkg::LOSS_M2};
            default: {g, l} = {liu_status_pkg::GAIN_M3, liu_status_pkg::LOSS_M3};
        endcase
        wr_ok(liu_status_pkg::IDX_MODE, {4'h0, v[3], 3'h0});
        wr_ok(liu_status_pkg::IDX_RXCTL, {v[3], 4'h0, v[2:0]});
        settle();
        check("monitor on", 32'(setup_o.monitor_on), 32'(v[2]));
        check("monitor gain", 32'(setup_o.monitor_gain_db), 32'(g));
        check("max loss", 32'(setup_o.max_loss_tenth_db), 32'(l));
        check("clock in", 32'(setup_o.clock_input_mode), 32'(v[3]));
        check("clock e1", 32'(setup_o.clock_expect_e1), 32'(v[3]));
    end
    wr_ok(liu_status_pkg::IDX_RXCTL, 8'hff);
    rd_check("rxctl mask", liu_status_pkg::IDX_RXCTL, 8'h8f);
endtask

////////////////////////////////////////////////////////////////////////////////
// Main sequence
initial
begin
    nrst_i = 1'b0;
    axi_i = '0;
    cond_i = '0;
    level_band_i = 4'h0;
    gain_cap_band_i = 4'hf;
    mismatches = 0;
    comparisons = 0;
    cycles = 0;
    repeat (20) @(posedge clk_i);
    nrst_i <= 1'b1;
    reset_values();
    events();
    csu_gate();
    level_band();
    termination();
    rx_control();
    close_out();
end

endmodule
